/* File: src/can_status_defines.svh */
`ifndef CAN_STATUS_DEFINES_SVH
`define CAN_STATUS_DEFINES_SVH

// register offsets
`define ADDR_RX_FLAGS 3'h0
`define ADDR_RX_IRQ_ENABLE 3'h1
`define ADDR_TX_FLAGS 3'h2
`define ADDR_TX_CONTROL 3'h3
`define ADDR_ACCEPT_CONTROL 3'h4
`define ADDR_RX_ERROR_COUNT 3'h5
`define ADDR_TX_ERROR_COUNT 3'h6
`define ADDR_SOFT_RESET 3'h7

// rx flag bit positions
`define BIT_WAKEUP 7
`define BIT_RX_WARNING 6
`define BIT_TX_WARNING 5
`define BIT_RX_PASSIVE 4
`define BIT_TX_PASSIVE 3
`define BIT_BUS_OFF 2
`define BIT_OVERRUN 1
`define BIT_RX_FULL 0

// reset values
`define RX_FLAGS_RESET 8'h00
`define RX_IRQ_ENABLE_RESET 8'h00
`define TX_EMPTY_RESET 3'h7
`define TX_ABORT_ACK_RESET 3'h0
`define TX_ABORT_REQ_RESET 3'h0
`define TX_EMPTY_IE_RESET 3'h0
`define FILTER_MODE_RESET 2'h0
`define FILTER_HIT_RESET 2'h0

// thresholds
`define WARNING_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h07f
`define BUS_OFF_LIMIT 9'h0ff
`define RECOVERY_SEQUENCES 8'h80

`endif

/* File: src/can_status_pkg.sv */
package can_status_pkg;

    typedef enum logic [1:0] {
        FILTER_ONE_32 = 2'h0,
        FILTER_TWO_16 = 2'h1,
        FILTER_FOUR_8 = 2'h2,
        FILTER_CLOSED = 2'h3
    } filter_mode_t;

    typedef enum logic [1:0] {
        BUS_ACTIVE = 2'h1,
        BUS_OFF = 2'h2
    } bus_state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic wakeup_irq;
        logic error_irq;
        logic rx_irq;
        logic [2:0] tx_empty_irq;
    } irq_lines_t;

    typedef struct packed {
        logic [7:0] rx_flags;
        logic [7:0] rx_irq_enable;
        logic [2:0] tx_empty;
        logic [2:0] abort_ack;
        logic [2:0] abort_req;
        logic [2:0] tx_empty_ie;
        filter_mode_t filter_mode;
        logic [1:0] filter_hit;
        logic soft_reset;
        bus_state_t bus_state;
        logic [7:0] recovery_count;
        logic [7:0] rdata;
    } state_t;

endpackage

/* File: src/can_status_irq.sv */
// Behaviour
// [RULE_01] tx warning flag sets when tx count above 96 and no passive/bus-off flag
// [RULE_02] rx passive flag sets when rx count above 127 and bus-off flag clear
// [RULE_03] tx passive flag sets when tx count in 128..255 and bus-off clear
// [RULE_04] bus-off flag and state set when tx count exceeds 255
// [RULE_05] bus-off flag cannot clear before 128 runs of 11 recessive bits
// [RULE_06] overrun flag sets on every receive overrun
// [RULE_07] rx full flag sets on accepted message; software clears to release
// [RULE_08] no background-to-foreground move while rx full flag is set
// [RULE_09] software reads receive buffer only while rx full flag set
// [RULE_10] flag, enable and tx control registers held at reset during soft reset
// [RULE_11] each flag raises its interrupt only with its enable set
// [RULE_12] writing one clears a status flag, zero leaves it; abort acks read only
// [RULE_13] software clears empty flag to schedule; device sets it after send
// [RULE_14] successful abort sets empty flag and abort ack; sent leaves ack clear
// [RULE_15] clearing empty clears abort ack; setting empty clears abort request
// [RULE_16] abort granted only before start or after failed attempt; cpu cannot clear
// [RULE_17] software never clears empty and sets abort request in one write
// [RULE_18] software avoids writing a scheduled transmit buffer
// [RULE_19] filter mode selects one, two, four filters or closed
// [RULE_20] hit index reports accepting filter, updated on each buffer copy
// [RULE_21] acceptance control writable only during soft reset
// [RULE_22] software reads error counters only in sleep or soft reset
// [RULE_23] rx warning flag sets when rx count above 96 and no passive/bus-off flag
// [RULE_24] soft reset aborts traffic, drops sync, keeps error counters
// [RULE_25] each interrupt line is or of flags anded with enables
`timescale 1ns/1ps
`include "can_status_defines.svh"

module can_status_irq (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire can_status_pkg::reg_req_t bus_req_in,
    output logic [7:0] bus_rdata_out,
    input wire logic [8:0] rx_error_count_in,
    input wire logic [8:0] tx_error_count_in,
    input wire logic wakeup_event_in,
    input wire logic overrun_event_in,
    input wire logic msg_accepted_in,
    input wire logic [1:0] msg_hit_index_in,
    output logic msg_copy_out,
    input wire logic recessive_run_in,
    input wire logic [2:0] tx_sent_in,
    input wire logic [2:0] tx_started_in,
    input wire logic [2:0] tx_failed_in,
    output logic [2:0] tx_scheduled_out,
    output logic [2:0] tx_abort_grant_out,
    output logic link_halt_out,
    output logic bus_off_out,
    output can_status_pkg::filter_mode_t filter_mode_out,
    output can_status_pkg::irq_lines_t irq_out
);

    can_status_pkg::state_t s_r;
    can_status_pkg::state_t s_nxt;
    logic [7:0] rx_set;
    logic [7:0] rx_clr;
    logic [2:0] grant;
    logic [2:0] tx_done;
    logic [2:0] tx_clr;
    logic wr_rxf;
    logic wr_txf;
    logic rx_pass;
    logic tx_pass;
    logic warn_block;
    logic copy;

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    always_comb begin
        wr_rxf = bus_req_in.wr && bus_req_in.addr == `ADDR_RX_FLAGS;
        wr_txf = bus_req_in.wr && bus_req_in.addr == `ADDR_TX_FLAGS;
        rx_pass = s_r.rx_flags[`BIT_RX_PASSIVE];
        tx_pass = s_r.rx_flags[`BIT_TX_PASSIVE];
        warn_block = rx_pass || tx_pass || s_r.rx_flags[`BIT_BUS_OFF];
        // copy only into a free foreground buffer and an open filter
        copy = msg_accepted_in && !s_r.rx_flags[`BIT_RX_FULL] // see [RULE_08]
            && s_r.filter_mode != can_status_pkg::FILTER_CLOSED; // see [RULE_19]
        rx_set = 8'h00;
        rx_set[`BIT_WAKEUP] = wakeup_event_in;
        rx_set[`BIT_RX_WARNING] = rx_error_count_in > `WARNING_LIMIT && !warn_block; // see [RULE_23]
        rx_set[`BIT_TX_WARNING] = tx_error_count_in > `WARNING_LIMIT && !warn_block; // see [RULE_01]
        rx_set[`BIT_RX_PASSIVE] = rx_error_count_in > `PASSIVE_LIMIT
            && !s_r.rx_flags[`BIT_BUS_OFF]; // see [RULE_02]
        rx_set[`BIT_TX_PASSIVE] = tx_error_count_in > `PASSIVE_LIMIT
            && tx_error_count_in <= `BUS_OFF_LIMIT && !s_r.rx_flags[`BIT_BUS_OFF]; // see [RULE_03]
        rx_set[`BIT_BUS_OFF] = tx_error_count_in > `BUS_OFF_LIMIT; // see [RULE_04]
        rx_set[`BIT_OVERRUN] = overrun_event_in; // see [RULE_06]
        rx_set[`BIT_RX_FULL] = copy; // see [RULE_07]
        rx_clr = wr_rxf ? bus_req_in.wdata : 8'h00; // see [RULE_12]
        // bus-off holds until recovery completes
        if (s_r.bus_state == can_status_pkg::BUS_OFF) begin
            rx_clr[`BIT_BUS_OFF] = 1'b0; // see [RULE_05]
        end
        grant = s_r.abort_req & ~s_r.tx_empty & (~tx_started_in | tx_failed_in) & ~tx_sent_in; // see [RULE_16]
        tx_done = (tx_sent_in & ~s_r.tx_empty) | grant; // see [RULE_13]
        tx_clr = wr_txf ? bus_req_in.wdata[2:0] : 3'h0;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.rx_flags = (s_r.rx_flags & ~rx_clr) | rx_set; // set wins over clear
        s_nxt.tx_empty = (s_r.tx_empty & ~tx_clr) | tx_done; // see [RULE_13]
        s_nxt.abort_ack = ((s_r.abort_ack & ~tx_clr) | grant) & ~(tx_clr & ~tx_done); // see [RULE_14] [RULE_15]
        s_nxt.abort_req = s_r.abort_req & ~tx_done; // see [RULE_15]
        if (copy) begin
            s_nxt.filter_hit = msg_hit_index_in; // see [RULE_20]
        end
        // bus-off recovery counter
        case (s_r.bus_state)
            can_status_pkg::BUS_ACTIVE: begin
                s_nxt.recovery_count = 8'h00;
                if (rx_set[`BIT_BUS_OFF]) begin
                    s_nxt.bus_state = can_status_pkg::BUS_OFF; // see [RULE_04]
                end
            end
            can_status_pkg::BUS_OFF: begin
                if (recessive_run_in && !s_r.soft_reset) begin
                    s_nxt.recovery_count = s_r.recovery_count + 8'h01;
                    if (s_r.recovery_count == `RECOVERY_SEQUENCES - 8'h01) begin
                        s_nxt.bus_state = can_status_pkg::BUS_ACTIVE; // see [RULE_05]
                    end
                end
            end
            default: begin
                s_nxt.bus_state = can_status_pkg::BUS_ACTIVE;
            end
        endcase
        if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                `ADDR_RX_IRQ_ENABLE: s_nxt.rx_irq_enable = bus_req_in.wdata;
                `ADDR_TX_CONTROL: begin
                    s_nxt.abort_req = s_nxt.abort_req | (bus_req_in.wdata[6:4] & ~s_r.tx_empty); // see [RULE_16]
                    s_nxt.tx_empty_ie = bus_req_in.wdata[2:0];
                end
                `ADDR_ACCEPT_CONTROL: begin
                    if (s_r.soft_reset) begin
                        s_nxt.filter_mode = can_status_pkg::filter_mode_t'(bus_req_in.wdata[5:4]); // see [RULE_21]
                    end
                end
                `ADDR_SOFT_RESET: s_nxt.soft_reset = bus_req_in.wdata[0];
                default: begin
                end
            endcase
        end
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                `ADDR_RX_FLAGS: s_nxt.rdata = s_r.rx_flags;
                `ADDR_RX_IRQ_ENABLE: s_nxt.rdata = s_r.rx_irq_enable;
                `ADDR_TX_FLAGS: s_nxt.rdata = {1'b0, s_r.abort_ack, 1'b0, s_r.tx_empty};
                `ADDR_TX_CONTROL: s_nxt.rdata = {1'b0, s_r.abort_req, 1'b0, s_r.tx_empty_ie};
                `ADDR_ACCEPT_CONTROL: s_nxt.rdata = {2'h0, s_r.filter_mode, 2'h0, s_r.filter_hit};
                `ADDR_RX_ERROR_COUNT: s_nxt.rdata = rx_error_count_in[7:0];
                `ADDR_TX_ERROR_COUNT: s_nxt.rdata = tx_error_count_in[7:0];
                `ADDR_SOFT_RESET: s_nxt.rdata = {7'h00, s_r.soft_reset};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // soft reset pins the flag, enable and tx control registers
        if (s_r.soft_reset) begin
            s_nxt.rx_flags = `RX_FLAGS_RESET; // see [RULE_10]
            s_nxt.rx_irq_enable = `RX_IRQ_ENABLE_RESET;
            s_nxt.tx_empty = `TX_EMPTY_RESET;
            s_nxt.abort_ack = `TX_ABORT_ACK_RESET;
            s_nxt.abort_req = `TX_ABORT_REQ_RESET;
            s_nxt.tx_empty_ie = `TX_EMPTY_IE_RESET;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_r.rx_flags <= `RX_FLAGS_RESET;
            s_r.rx_irq_enable <= `RX_IRQ_ENABLE_RESET;
            s_r.tx_empty <= `TX_EMPTY_RESET;
            s_r.abort_ack <= `TX_ABORT_ACK_RESET;
            s_r.abort_req <= `TX_ABORT_REQ_RESET;
            s_r.tx_empty_ie <= `TX_EMPTY_IE_RESET;
            s_r.filter_mode <= can_status_pkg::FILTER_ONE_32;
            s_r.filter_hit <= `FILTER_HIT_RESET;
            s_r.soft_reset <= 1'b0;
            s_r.bus_state <= can_status_pkg::BUS_ACTIVE;
            s_r.recovery_count <= 8'h00;
            s_r.rdata <= 8'h00;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        bus_rdata_out = s_r.rdata;
        msg_copy_out = copy;
        tx_scheduled_out = ~s_r.tx_empty;
        tx_abort_grant_out = grant;
        link_halt_out = s_r.soft_reset; // see [RULE_24]
        bus_off_out = s_r.bus_state == can_status_pkg::BUS_OFF;
        filter_mode_out = s_r.filter_mode; // see [RULE_19]
        irq_out.wakeup_irq = s_r.rx_flags[`BIT_WAKEUP] & s_r.rx_irq_enable[`BIT_WAKEUP]; // see [RULE_11]
        irq_out.error_irq = |(s_r.rx_flags[6:1] & s_r.rx_irq_enable[6:1]); // see [RULE_25]
        irq_out.rx_irq = s_r.rx_flags[`BIT_RX_FULL] & s_r.rx_irq_enable[`BIT_RX_FULL];
        irq_out.tx_empty_irq = s_r.tx_empty & s_r.tx_empty_ie; // see [RULE_11]
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence busoff_entry_s;
        tx_error_count_in > `BUS_OFF_LIMIT && !s_r.soft_reset;
    endsequence

    property busoff_flag_p;
        @(posedge clk_sys_in) disable iff (rst_in)
        busoff_entry_s |=> s_r.rx_flags[`BIT_BUS_OFF] && bus_off_out;
    endproperty

    bus_off_set_a: assert property (busoff_flag_p) else $error("bus-off not entered"); // see [RULE_04]

    busoff_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_05]
        bus_off_out && s_r.rx_flags[`BIT_BUS_OFF] && !s_r.soft_reset
        |=> s_r.rx_flags[`BIT_BUS_OFF]) else $error("bus-off flag cleared early");

    rx_full_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_08]
        s_r.rx_flags[`BIT_RX_FULL] |-> !msg_copy_out) else $error("copy into full buffer");

    soft_reset_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_10]
        s_r.soft_reset ##1 s_r.soft_reset |-> s_r.rx_flags == 8'h00 && s_r.tx_empty == 3'h7)
        else $error("registers not held in soft reset");

    error_irq_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_25]
        s_r.rx_flags[`BIT_OVERRUN] && s_r.rx_irq_enable[`BIT_OVERRUN] |-> irq_out.error_irq)
        else $error("error interrupt missing");

    abort_ack_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_14]
        grant[0] && !s_r.soft_reset |=> s_r.tx_empty[0] && s_r.abort_ack[0] && !s_r.abort_req[0])
        else $error("abort not acknowledged");

    sent_no_ack_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_14]
        tx_sent_in[0] && !s_r.tx_empty[0] && !s_r.abort_ack[0] && !s_r.soft_reset |=> !s_r.abort_ack[0])
        else $error("ack set on sent message");

    accept_lock_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_21]
        !s_r.soft_reset |=> $stable(s_r.filter_mode)) else $error("filter mode written outside soft reset");

    hit_update_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // see [RULE_20]
        msg_copy_out |=> s_r.filter_hit == $past(msg_hit_index_in)) else $error("hit index not updated");

endmodule // can_status_irq

/* File: dv/can_bus_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// far-side node: sends scheduled buffers, idles the bus
// ------------------------------------------------------------
module can_bus_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [2:0] tx_scheduled_in,
    input wire logic [2:0] hold_in,
    input wire logic idle_in,
    output logic [2:0] tx_sent_out,
    output logic [2:0] tx_started_out,
    output logic recessive_run_out
);
    logic [2:0] cnt_r [3];
    logic [3:0] bit_r;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            tx_started_out[i] = cnt_r[i] != 3'h0;
        end
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '{3'h0, 3'h0, 3'h0};
            tx_sent_out <= 3'h0;
            bit_r <= 4'h0;
            recessive_run_out <= 1'b0;
        end else begin
            // held buffers never start, so they stay abortable
            for (int i = 0; i < 3; i++) begin
                tx_sent_out[i] <= cnt_r[i] == 3'h7;
                cnt_r[i] <= (tx_scheduled_in[i] && !hold_in[i] && !tx_sent_out[i]) ? cnt_r[i] + 3'h1 : 3'h0;
            end
            // one pulse per 11 idle bit times
            bit_r <= (idle_in && bit_r != 4'ha) ? bit_r + 4'h1 : 4'h0;
            recessive_run_out <= idle_in && bit_r == 4'ha;
        end
    end
endmodule // can_bus_model

/* File: dv/can_status_irq_tb_top.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------
module can_status_irq_tb_top;
    logic clk_sys_in, rst_in, wake, ovr, acc, copy, run, halt, boff, idle;
    can_status_pkg::reg_req_t req;
    can_status_pkg::filter_mode_t fmode;
    can_status_pkg::irq_lines_t irq;
    logic [7:0] d, m;
    logic [8:0] rx_cnt, tx_cnt, rv, tv;
    logic [1:0] hit, h;
    logic [2:0] sent, started, sched, grant, hold, fail;
    logic [31:0] seed = 32'h9043;
    int n_errors = 0;
    int num_checks = 0;
    int n_grant = 0;
    int n_run = 0;
    can_status_irq u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_req_in(req), .bus_rdata_out(d),
        .rx_error_count_in(rx_cnt), .tx_error_count_in(tx_cnt), .wakeup_event_in(wake), .overrun_event_in(ovr),
        .msg_accepted_in(acc), .msg_hit_index_in(hit), .msg_copy_out(copy), .recessive_run_in(run),
        .tx_sent_in(sent), .tx_started_in(started), .tx_failed_in(fail), .tx_scheduled_out(sched),
        .tx_abort_grant_out(grant), .link_halt_out(halt), .bus_off_out(boff), .filter_mode_out(fmode),
        .irq_out(irq));
    can_bus_model u_bus (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tx_scheduled_in(sched), .hold_in(hold),
        .idle_in(idle), .tx_sent_out(sent), .tx_started_out(started), .recessive_run_out(run));
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        n_grant <= n_grant + ((grant !== 3'h0) ? 1 : 0);
        n_run <= n_run + ((run === 1'b1) ? 1 : 0);
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] acc_val(input logic [1:0] mode, input logic [1:0] idx);
        return {2'h0, mode, 2'h0, idx};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        req.wr <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] msk, input logic [7:0] exp);
        logic [7:0] v;
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        req.rd <= 1'b0;
        #1 v = d;
        chk(v & msk, exp);
        @(posedge clk_sys_in);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchdog: whole run needs about 1700 cycles
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_errors++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        req = '0;
        {rx_cnt, tx_cnt, wake, ovr, acc, hit, hold, fail, idle} = '0;
        rst_in = 1'b1;
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        rdc(3'h0, 8'hff, 8'h00);
        rdc(3'h2, 8'hff, 8'h07);
        chk({2'h0, irq}, 8'h00);
        for (int k = 0; k < 5; k++) begin
            rv = 9'h0;
            tv = 9'h0;
            case (k)
                0: tv = 9'h060;
                1: tv = 9'h061 + 9'(rnd() % 31);
                2: rv = 9'h061 + 9'(rnd() % 31);
                3: rv = 9'h080 + 9'(rnd() % 128);
                default: tv = 9'h080 + 9'(rnd() % 128);
            endcase
            m = (k == 0) ? 8'h00 : (k == 1) ? 8'h20 : (k == 2) ? 8'h40 : (k == 3) ? 8'h10 : 8'h08;
            wr(3'h1, 8'hff);
            rx_cnt <= rv;
            tx_cnt <= tv;
            repeat (2) @(posedge clk_sys_in);
            rdc(3'h0, (k == 0) ? 8'hff : m, m);
            chk({7'h0, irq.error_irq}, {7'h0, k != 0});
            rx_cnt <= 9'h0;
            tx_cnt <= 9'h0;
            wr(3'h7, 8'h01);
            wr(3'h7, 8'h00);
        end
        $display("test thresholds done");
        tx_cnt <= 9'h100 + 9'(rnd() % 200);
        wr(3'h1, 8'h04);
        chk({6'h0, boff, irq.error_irq}, 8'h03);
        tx_cnt <= 9'h0;
        idle <= 1'b1;
        for (int i = 0; i < 2000 && n_run < 127; i++) @(posedge clk_sys_in);
        idle <= 1'b0;
        wr(3'h0, 8'h04);
        rdc(3'h0, 8'h04, 8'h04);
        idle <= 1'b1;
        for (int i = 0; i < 50 && n_run < 128; i++) @(posedge clk_sys_in);
        idle <= 1'b0;
        wr(3'h0, 8'h04);
        rdc(3'h0, 8'h04, 8'h00);
        chk({7'h0, boff}, 8'h00);
        $display("test bus off done");
        rv = 9'(rnd() % 96);
        rx_cnt <= rv;
        tx_cnt <= rv ^ 9'h015;
        wr(3'h7, 8'h01);
        wr(3'h1, 8'hff);
        wr(3'h3, 8'h77);
        rdc(3'h1, 8'hff, 8'h00);
        rdc(3'h3, 8'hff, 8'h00);
        rdc(3'h5, 8'hff, rv[7:0]);
        rdc(3'h6, 8'hff, rv[7:0] ^ 8'h15);
        chk({7'h0, halt}, 8'h01);
        wr(3'h7, 8'h00);
        rx_cnt <= 9'h0;
        tx_cnt <= 9'h0;
        wr(3'h4, 8'h30);
        rdc(3'h4, 8'h30, 8'h00);
        for (int k = 0; k < 4; k++) begin
            h = 2'(rnd());
            wr(3'h7, 8'h01);
            wr(3'h4, acc_val(2'(k), 2'h0));
            wr(3'h7, 8'h00);
            wr(3'h1, 8'h01);
            chk({6'h0, fmode}, {6'h0, 2'(k)});
            acc <= 1'b1;
            hit <= h;
            #1 chk({7'h0, copy}, {7'h0, k != 3});
            @(posedge clk_sys_in);
            acc <= 1'b0;
            @(posedge clk_sys_in);
            rdc(3'h4, (k == 3) ? 8'h30 : 8'h33, acc_val(2'(k), (k == 3) ? 2'h0 : h));
            rdc(3'h0, 8'hff, {7'h0, k != 3});
            chk({7'h0, irq.rx_irq}, {7'h0, k != 3});
            if (k == 0) begin
                acc <= 1'b1;
                hit <= ~h;
                #1 chk({7'h0, copy}, 8'h00);
                @(posedge clk_sys_in);
                acc <= 1'b0;
                wr(3'h0, 8'h00);
                rdc(3'h4, 8'h03, {6'h0, h});
                rdc(3'h0, 8'h01, 8'h01);
            end
            wr(3'h0, 8'h01);
            rdc(3'h0, 8'hff, 8'h00);
        end
        $display("test filter done");
        wr(3'h1, 8'h80);
        wake <= 1'b1;
        ovr <= 1'b1;
        @(posedge clk_sys_in);
        wake <= 1'b0;
        ovr <= 1'b0;
        rdc(3'h0, 8'hff, 8'h82);
        chk({6'h0, irq.wakeup_irq, irq.error_irq}, 8'h02);
        wr(3'h1, 8'h02);
        chk({6'h0, irq.wakeup_irq, irq.error_irq}, 8'h01);
        wr(3'h0, 8'h82);
        rdc(3'h0, 8'hff, 8'h00);
        $display("test events done");
        wr(3'h3, 8'h07);
        chk({5'h0, irq.tx_empty_irq}, 8'h07);
        hold <= 3'h2;
        wr(3'h2, 8'h02); // schedule alone, abort in a later write
        chk({4'h0, sched, irq.tx_empty_irq[1]}, 8'h04);
        wr(3'h3, 8'h27);
        repeat (2) @(posedge clk_sys_in);
        rdc(3'h2, 8'hff, 8'h27);
        rdc(3'h3, 8'hff, 8'h07);
        chk(8'(n_grant), 8'h01);
        wr(3'h2, 8'h22);
        rdc(3'h2, 8'hff, 8'h05);
        hold <= 3'h0;
        for (int i = 0; i < 50 && sched !== 3'h0; i++) @(posedge clk_sys_in);
        rdc(3'h2, 8'hff, 8'h07);
        wr(3'h2, 8'h04);
        for (int i = 0; i < 20 && started[2] !== 1'b1; i++) @(posedge clk_sys_in);
        wr(3'h3, 8'h47);
        for (int i = 0; i < 50 && sched !== 3'h0; i++) @(posedge clk_sys_in);
        rdc(3'h2, 8'hff, 8'h07);
        rdc(3'h3, 8'hff, 8'h07);
        chk(8'(n_grant), 8'h01);
        wr(3'h2, 8'h01);
        for (int i = 0; i < 20 && started[0] !== 1'b1; i++) @(posedge clk_sys_in);
        fail <= 3'h1;
        wr(3'h3, 8'h17);
        fail <= 3'h0;
        rdc(3'h2, 8'hff, 8'h17);
        chk(8'(n_grant), 8'h02);
        $display("test transmit done");
        give_verdict();
    end
endmodule // can_status_irq_tb_top
